//--- rtl/pattern_output_defs.svh
// register offsets, reset values and field positions of the pattern output unit
`ifndef PATTERN_OUTPUT_DEFS_SVH
`define PATTERN_OUTPUT_DEFS_SVH
`define OFS_NEXT_DATA_LOW     12'h000
`define OFS_NEXT_DATA_HIGH    12'h004
`define OFS_NEXT_ENABLE_LOW   12'h008
`define OFS_NEXT_ENABLE_HIGH  12'h00C
`define OFS_PORT_LOW_DATA     12'h010
`define OFS_PORT_HIGH_DATA    12'h014
`define OFS_PORT_LOW_DIR      12'h018
`define OFS_PORT_HIGH_DIR     12'h01C
`define OFS_TRIGGER_SELECT    12'h020
`define OFS_GROUP_MODE        12'h024
`define OFS_PIN_LEVEL         12'h028
`define RST_GROUP_MODE        8'hF0
`define RST_TRIGGER_SELECT    8'hFF
`define RST_BYTE              8'h00
`define MODE_RESERVED_MASK    8'hF0
`define GROUP_WIDTH           4
`define GROUP_COUNT           4
`endif

//--- rtl/pattern_output_pkg.sv
// types shared by the pattern output unit
package pattern_output_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] pins_t;
  typedef logic [2:0]  chan_t;
endpackage

//--- rtl/pattern_output_unit.sv
// timed pattern output unit: apb registers, trigger transfer, pin drivers
`include "pattern_output_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pattern_output_unit
#(
  parameter int NUM_CHANNELS = 3
)
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       hw_standby,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NUM_CHANNELS-1:0]    compare_a,
  input  wire logic [NUM_CHANNELS-1:0]    compare_b,
  input  wire logic [NUM_CHANNELS-1:0]    capture_a,
  input  wire logic [NUM_CHANNELS-1:0]    capture_mode_a,
  input  wire pattern_output_pkg::pins_t  alt_function_en,
  input  wire pattern_output_pkg::pins_t  pin_in,
  output pattern_output_pkg::pins_t       pin_out,
  output pattern_output_pkg::pins_t       pin_oe,
  output pattern_output_pkg::pins_t       pattern_active,
  output logic                            evt_valid,
  input  wire logic                       evt_ready,
  output pattern_output_pkg::pins_t       evt_data
);
  import pattern_output_pkg::*;

  // software visible registers and the two pin synchroniser stages
  byte_t group_mode;
  byte_t trigger_select;
  pins_t next_data;
  pins_t next_enable;
  pins_t port_data;
  pins_t port_dir;
  pins_t pin_sync1;
  pins_t pin_sync2;

  // maps a two-bit select field to a channel one-hot
  function automatic chan_t chan_of(input logic [1:0] sel);
    chan_t c;
    c = 3'h0;
    unique case (sel)
      2'b00: c = 3'h1;
      2'b01: c = 3'h2;
      default: c = 3'h4;
    endcase
    return c;
  endfunction

  // apb decode
  wire access_phase = psel & penable;
  wire wr_en        = access_phase & pwrite;
  wire hit_ndl  = paddr == `OFS_NEXT_DATA_LOW;
  wire hit_ndh  = paddr == `OFS_NEXT_DATA_HIGH;
  wire hit_nel  = paddr == `OFS_NEXT_ENABLE_LOW;
  wire hit_neh  = paddr == `OFS_NEXT_ENABLE_HIGH;
  wire hit_pdl  = paddr == `OFS_PORT_LOW_DATA;
  wire hit_pdh  = paddr == `OFS_PORT_HIGH_DATA;
  wire hit_dirl = paddr == `OFS_PORT_LOW_DIR;
  wire hit_dirh = paddr == `OFS_PORT_HIGH_DIR;
  wire hit_tsel = paddr == `OFS_TRIGGER_SELECT;
  wire hit_mode = paddr == `OFS_GROUP_MODE;
  wire hit_pin  = paddr == `OFS_PIN_LEVEL;
  wire mapped   = hit_ndl | hit_ndh | hit_nel | hit_neh | hit_pdl | hit_pdh
                | hit_dirl | hit_dirh | hit_tsel | hit_mode | hit_pin;

  // zero-wait slave; unmapped addresses get an error and no store
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // trigger routing per group, chosen by the select field
  logic [`GROUP_COUNT-1:0] trig_a;
  logic [`GROUP_COUNT-1:0] trig_b;
  pins_t                   copy_mask;
  genvar g;
  generate
    for (g = 0; g < `GROUP_COUNT; g = g + 1)
    begin : grp
      wire chan_t sel_oh = chan_of(trigger_select[2*g+1 -: 2]);
      // capture mode on timer a swaps the compare event for the capture event
      wire [NUM_CHANNELS-1:0] ev_a = (compare_a & ~capture_mode_a)
                                   | (capture_a & capture_mode_a);
      wire src_a = |(ev_a & sel_oh[NUM_CHANNELS-1:0]);
      wire src_b = |(compare_b & sel_oh[NUM_CHANNELS-1:0]);
      wire nov   = group_mode[g];
      assign trig_a[g] = src_a;
      assign trig_b[g] = nov & src_b & ~src_a;
      // match b moves only zeros; match a moves every enabled bit
      assign copy_mask[4*g +: 4] = next_enable[4*g +: 4]
                                 & ({4{trig_a[g]}}
                                 | ({4{trig_b[g]}} & ~next_data[4*g +: 4]));
    end
  endgenerate

  // the copy ignores pin ownership so alternate functions never desync it
  wire pins_t next_port_data = (port_data & ~copy_mask) | (next_data & copy_mask);
  wire any_copy = |copy_mask;

  // software writes to data bits; read-only when enabled as input
  wire pins_t sw_lock = next_enable & ~port_dir;

  // register file; hardware standby resets as a synchronous clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group_mode     <= `RST_GROUP_MODE;
      trigger_select <= `RST_TRIGGER_SELECT;
      next_data      <= 16'h0000;
      next_enable    <= 16'h0000;
      port_dir       <= 16'h0000;
    end
    else if (hw_standby)
    begin
      group_mode     <= `RST_GROUP_MODE;
      trigger_select <= `RST_TRIGGER_SELECT;
      next_data      <= 16'h0000;
      next_enable    <= 16'h0000;
      port_dir       <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (hit_mode) group_mode <= `MODE_RESERVED_MASK | pwdata[7:0];
      if (hit_tsel) trigger_select <= pwdata[7:0];
      if (hit_ndl) next_data[7:0] <= pwdata[7:0];
      if (hit_ndh) next_data[15:8] <= pwdata[7:0];
      if (hit_nel) next_enable[7:0] <= pwdata[7:0];
      if (hit_neh) next_enable[15:8] <= pwdata[7:0];
      if (hit_dirl) port_dir[7:0] <= pwdata[7:0];
      if (hit_dirh) port_dir[15:8] <= pwdata[7:0];
    end
  end

  // port data: trigger copy wins over a software write in the same cycle
  wire pins_t sw_wr_mask = {{8{wr_en & hit_pdh}}, {8{wr_en & hit_pdl}}} & ~sw_lock;
  wire pins_t sw_value   = {pwdata[7:0], pwdata[7:0]};
  wire pins_t next_port  = (port_data & ~sw_wr_mask & ~copy_mask)
                         | (sw_value & sw_wr_mask & ~copy_mask)
                         | (next_port_data & copy_mask);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_data <= 16'h0000;
    else if (hw_standby)
      port_data <= 16'h0000;
    else
      port_data <= next_port;
  end

  // two-flop synchroniser for pin levels read by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync1 <= 16'h0000;
      pin_sync2 <= 16'h0000;
    end
    else
    begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // pin drivers; alternate functions take the pin away from the port
  assign pattern_active = port_dir & next_enable & ~alt_function_en;
  assign pin_oe         = port_dir & ~alt_function_en;
  assign pin_out        = port_data & pin_oe;

  // read mux; input pins show their synchronised level
  wire pins_t data_view = (port_data & port_dir) | (pin_sync2 & ~port_dir);
  wire byte_t rd_byte =
      hit_ndl  ? next_data[7:0]    :
      hit_ndh  ? next_data[15:8]   :
      hit_nel  ? next_enable[7:0]  :
      hit_neh  ? next_enable[15:8] :
      hit_pdl  ? data_view[7:0]    :
      hit_pdh  ? data_view[15:8]   :
      hit_dirl ? port_dir[7:0]     :
      hit_dirh ? port_dir[15:8]    :
      hit_tsel ? trigger_select    :
      hit_mode ? group_mode        :
      hit_pin  ? pin_sync2[7:0]    : 8'h00;
  assign prdata = {24'h000000, rd_byte};

  // two-entry buffer of post-transfer port values for an event monitor
  pins_t     buf_data [2];
  logic      wr_ptr;
  logic      rd_ptr;
  logic [1:0] count;
  wire push = any_copy & (count != 2'd2);
  wire pop  = evt_valid & evt_ready;
  assign evt_valid = count != 2'd0;
  assign evt_data  = buf_data[rd_ptr];
  // a full buffer drops further snapshots; port data itself never stalls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_data[0] <= 16'h0000;
      buf_data[1] <= 16'h0000;
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      count       <= 2'd0;
    end
    else
    begin
      if (push) buf_data[wr_ptr] <= next_port;
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

//--- sim/pattern_output_props.sv
// port assertions for the pattern output unit
`timescale 1ns/1ps
`default_nettype none
module pattern_output_props (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, evt_valid, evt_ready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [15:0] alt_function_en, pin_out, pin_oe, pattern_active, evt_data
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access-phase read, and a word the sink refuses
  wire rd = psel && penable && !pwrite;
  sequence s_stall; evt_valid && !evt_ready; endsequence
  a_zero_wait: assert property (psel && penable |-> pready) else $error("ready low in access");
  a_alt_undriven: assert property ((pin_oe & alt_function_en) == 0) else $error("alt pin driven");
  a_out_gated: assert property ((pin_out & ~pin_oe) == 0) else $error("high on undriven pin");
  a_active_driven: assert property ((pattern_active & ~pin_oe) == 0) else $error("idle pattern");
  a_mode_ones: assert property (rd && paddr==12'h024 |-> &prdata[7:4]) else $error("mode bits");
  a_read_upper: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h028 |-> pslverr) else $error("no err");
  a_stall_holds: assert property (s_stall |=> evt_valid && $stable(evt_data)) else $error("word lost");
endmodule
bind pattern_output_unit pattern_output_props props (.*);
`default_nettype wire

//--- sim/pin_load.sv
// far side: pull-up loads on the pattern pins and an event sink that can stall
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic [15:0] pin_out, pin_oe,
  input  wire logic        stall,
  output logic      [15:0] pin_in,
  output logic             evt_ready
);
  // released pins float high; the sink refuses words only while told to stall
  assign pin_in = pin_out | ~pin_oe;
  assign evt_ready = !stall;
endmodule
`default_nettype wire

//--- sim/timed_pattern_output_groups_bench.sv
// self-checking bench for the timed pattern output unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: %h %h", $time, a, b); end end
module timed_pattern_output_groups_bench;
  logic        pclk = 0, presetn, hw_standby, psel, penable, pwrite, pready, pslverr;
  logic        evt_valid, evt_ready, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  compare_a, compare_b, capture_a, capture_mode_a;
  logic [15:0] alt_function_en, pin_in, pin_out, pin_oe, pattern_active, evt_data;
  int          bad_count, num_checks;
  pattern_output_unit dut (.*);
  pin_load load (.*);
  // 100 MHz clock, and a watchdog that counts a hang as a mismatch
  initial forever #5 pclk = ~pclk;
  initial #20000 wrap_up(1);
  // apb transfer held until pready is seen; a read compares its low byte with d
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) `CHK(prdata[7:0], d)
    `CHK(pslverr, a > 12'h028)
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // one-cycle timer events per channel: compare a, compare b, capture
  task automatic trig(input logic [2:0] a, b, c);
    {compare_a, compare_b, capture_a} <= {a, b, c};
    @(posedge pclk) {compare_a, compare_b, capture_a} <= 9'h0;
    @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(0, 12'h024, 8'hF0);
    apb(0, 12'h020, 8'hFF);
    apb(1, 12'h024, 8'h0C);
    apb(0, 12'h024, 8'hFC);
    hw_standby <= 1;
    @(posedge pclk) hw_standby <= 0;
    apb(0, 12'h024, 8'hF0);
    apb(1, 12'h040, 8'h55);
    $display("regs end");
  endtask
  task automatic t_normal;
    apb(1, 12'h018, 8'hFF);
    apb(1, 12'h008, 8'h0F);
    apb(1, 12'h020, 8'hFC);
    apb(1, 12'h000, 8'hF5);
    trig(3'b110, 3'b001, 0);
    `CHK(pin_out[7:0], 8'h00)
    trig(3'b001, 0, 0);
    `CHK(pin_out[7:0], 8'h05)
    `CHK(pattern_active[7:0], 8'h0F)
    $display("normal end");
  endtask
  task automatic t_triggers;
    apb(1, 12'h024, 8'h01);
    apb(1, 12'h000, 8'h0A);
    trig(0, 3'b001, 0);
    `CHK(pin_out[3:0], 4'h0)
    trig(3'b001, 0, 0);
    `CHK(pin_out[3:0], 4'hA)
    capture_mode_a <= 3'b001;
    alt_function_en <= 16'h0001;
    apb(1, 12'h000, 8'h07);
    trig(0, 0, 3'b001);
    alt_function_en <= 16'h0000;
    @(posedge pclk) `CHK(pin_out[3:0], 4'h7)
    stall <= 1;
    repeat (3) trig(0, 0, 3'b001);
    stall <= 0;
    @(negedge pclk) `CHK(evt_valid, 1'b1)
    `CHK(evt_data, 16'h0007)
    @(negedge pclk) `CHK(evt_valid, 1'b1)
    @(negedge pclk) `CHK(evt_valid, 1'b0)
    $display("trigger end");
  endtask
  // five cycles of reset, then the scenarios in turn
  initial
  begin
    {presetn, hw_standby, psel, penable, pwrite, stall, paddr, pwdata} = 0;
    {compare_a, compare_b, capture_a, capture_mode_a, alt_function_en} = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_normal;
    t_triggers;
    wrap_up(0);
  end
  // counts, verdict and end of run
  task automatic wrap_up(input int hang);
    bad_count += hang;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
endmodule
`default_nettype wire
